// *** src/beq_pkg.sv ***
// package: constants and types for the bus event qualifier counter
package beq_pkg;
    // allocation qualifier mask field positions
    localparam int QM_REQ_LSB = 0;
    localparam int QM_REQ_W = 5;
    localparam int QM_ALL_READ = 5;
    localparam int QM_ALL_WRITE = 6;
    localparam int QM_MEM_LSB = 7;
    localparam int QM_MEM_W = 5;
    localparam int QM_OWN = 13;
    localparam int QM_OTHER = 14;
    localparam int QM_PREFETCH = 15;
    localparam int MASK_W = 16;
    localparam logic [4:0] REQ_TYPE_DEFAULT = 5'h01;
    // data activity mask positions
    localparam int DA_DRV = 0;
    localparam int DA_OWN = 1;
    // activity lengths in processor clocks
    localparam int PARTIAL_CLKS = 2;
    localparam int FULL_CLKS = 4;
    localparam int NEW_MODEL_MIN = 2;
    // granularity of one allocation
    localparam int LINE_BYTES = 64;
    localparam int CHUNK_BYTES = 8;
    localparam int CNT_W = 40;
    localparam logic [CNT_W-1:0] CNT_RESET = 40'h00_0000_0000;

    // one bus request as seen by the queue
    typedef struct packed {
        logic valid;
        logic [4:0] req_type;
        logic is_read;
        logic is_write;
        logic [4:0] mem_type;   // one-hot: uc, wc, wt, wp, wb
        logic own;
        logic prefetch;
        logic full_line;
    } beq_req_t;

    // one data phase on the shared bus
    typedef struct packed {
        logic start;
        logic drive;            // this processor drives data
        logic read;             // this processor samples data
        logic full_line;
    } beq_data_t;

    typedef enum logic {BEQ_EVT_ALLOC, BEQ_EVT_DATA} beq_evt_t;
endpackage : beq_pkg

// *** src/beq_phase_gen.sv ***
// stretches one data-phase start into a drive/read level of 2 or 4 clocks
`timescale 1ns/1ps
`default_nettype none
module beq_phase_gen
    import beq_pkg::*;
(
    input wire logic clk,           // processor clock
    input wire logic reset,         // async reset, active high
    input wire logic start,         // phase start pulse
    input wire logic full_line,     // full line length
    output logic active             // condition level
);
    logic [2:0] left_r;
    logic [2:0] left_nxt;

    // load the length on start, then count down
    always_comb begin
        left_nxt = left_r;
        if (start)
            left_nxt = full_line ? 3'(FULL_CLKS) : 3'(PARTIAL_CLKS);
        else if (left_r != 3'h0)
            left_nxt = left_r - 3'h1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            left_r <= 3'h0;
        else
            left_r <= left_nxt;
    end

    assign active = (left_r != 3'h0);
endmodule : beq_phase_gen
`default_nettype wire

// *** src/beq_counter.sv ***
// event counter with level or rising-edge counting
`timescale 1ns/1ps
`default_nettype none
module beq_counter
    import beq_pkg::*;
#(
    parameter int W = CNT_W
)
(
    input wire logic clk,           // processor clock
    input wire logic reset,         // async reset, active high
    input wire logic enable,        // counter enabled
    input wire logic edge_mode,     // count rising edges only
    input wire logic clear,         // zero the count
    input wire logic event_in,      // qualified event level
    output logic [W-1:0] count      // running count
);
    logic prev_r;

    // previous event level for edge detection
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            prev_r <= 1'b0;
        else
            prev_r <= event_in;
    end

    // one per active clock, or per rising edge in edge mode
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            count <= W'(0);
        else if (clear)
            count <= W'(0);
        else if (enable && event_in && (!edge_mode || !prev_r))
            count <= count + W'(1);
    end
endmodule : beq_counter
`default_nettype wire

// *** src/beq_top.sv ***
// bus event qualifier: allocation and data activity events feeding one counter
//
// Notes on behaviour
// R1: with the other-agent bit set, requests driven by other processors or dma are counted.
// R2: with the prefetch bit set, hardware and software prefetches are counted too; otherwise they are dropped.
// R3: software should not use edge counting when counting allocation cycles.
// R4: on newer models the event is request type AND read-or-write selector AND memory type AND source agent.
// R5: on older models the event is source agent AND (request type OR read OR write OR memory type).
// R6: on older models memory-type bits are ignored when the all-read or all-write selector is set.
// R7: privilege level is not used to filter allocations; user and system requests both count.
// R8: each allocation counts once, whether a full 64-byte line or an 8-byte chunk.
// R9: the data activity event counts data-ready or data-busy conditions chosen by its mask bits.
// R10: with the drive-data selector set, clocks where this processor drives data are counted.
// R11: the drive condition lasts two clocks for partial writes and four for full-line writes.
// R12: with the own-read selector set, clocks where this processor samples data count, two or four clocks long.
// R13: mask bits zero to four form one request type field, 00001 being the default or invalid code.
// R14: the own-agent bit selects requests driven by this processor.
// R15: software should use edge counting for the data activity event to avoid double counting.
// R16: the event is evaluated every clock and counted per active clock, or per rising edge in edge mode.
`timescale 1ns/1ps
`default_nettype none
module beq_top
    import beq_pkg::*;
#(
    parameter int CW = CNT_W
)
(
    input wire logic clk,                   // processor clock, 25 MHz
    input wire logic reset,                 // async reset, active high
    input wire logic [MASK_W-1:0] evt_mask, // event select mask field
    input wire beq_evt_t evt_sel,           // which event the counter takes
    input wire logic new_model,             // model field is NEW_MODEL_MIN or more
    input wire logic cnt_enable,            // counter enable
    input wire logic edge_mode,             // count rising edges
    input wire logic cnt_clear,             // zero the counter
    input wire beq_req_t req,               // queue allocation in this clock
    input wire logic privilege_level,       // current privilege, unused
    input wire beq_data_t data,             // data phase start on the bus
    output logic alloc_event,               // qualified allocation event
    output logic data_event,                // qualified data activity event
    output logic drive_active,              // drive-data condition level
    output logic read_active,               // own-read condition level
    output logic [CW-1:0] count             // counter value
);
    logic req_match;
    logic rw_match;
    logic mem_match;
    logic src_match;
    logic pf_ok;
    logic alloc_comb;
    logic data_comb;
    logic sel_event;
    logic [4:0] mem_bits;

    // field extraction
    assign mem_bits = evt_mask[QM_MEM_LSB +: QM_MEM_W];

    // request type: default code matches any request
    always_comb begin
        req_match = req.req_type == evt_mask[QM_REQ_LSB +: QM_REQ_W]; // see R13
        if (evt_mask[QM_REQ_LSB +: QM_REQ_W] == REQ_TYPE_DEFAULT)
            req_match = 1'b1; // see R13
    end

    // read or write selector, memory type, source agent
    assign rw_match = (evt_mask[QM_ALL_READ] && req.is_read) || (evt_mask[QM_ALL_WRITE] && req.is_write);
    assign mem_match = |(mem_bits & req.mem_type);
    assign src_match = (evt_mask[QM_OWN] && req.own) // see R14
        || (evt_mask[QM_OTHER] && !req.own); // see R1
    assign pf_ok = !req.prefetch || evt_mask[QM_PREFETCH]; // see R2

    // model dependent expression; privilege level deliberately unused
    always_comb begin
        if (new_model)
            alloc_comb = req_match && rw_match && mem_match && src_match; // see R4
        else if (evt_mask[QM_ALL_READ] || evt_mask[QM_ALL_WRITE])
            alloc_comb = src_match && (req_match || rw_match); // see R6
        else
            alloc_comb = src_match && (req_match || mem_match); // see R5
        alloc_comb = alloc_comb && req.valid && pf_ok; // see R7
    end

    // one count per allocation, line or chunk alike
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            alloc_event <= 1'b0;
        else
            alloc_event <= alloc_comb; // see R8
    end

    // drive-data and own-read condition stretchers
    beq_phase_gen u_drive (
        .clk(clk),
        .reset(reset),
        .start(data.start && data.drive), // see R11
        .full_line(data.full_line),
        .active(drive_active)
    );

    beq_phase_gen u_read (
        .clk(clk),
        .reset(reset),
        .start(data.start && data.read), // see R12
        .full_line(data.full_line),
        .active(read_active)
    );

    // data activity selection
    assign data_comb = (evt_mask[DA_DRV] && drive_active) // see R10
        || (evt_mask[DA_OWN] && read_active); // see R9

    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            data_event <= 1'b0;
        else
            data_event <= data_comb; // see R12
    end

    // counter takes the selected event each clock
    assign sel_event = (evt_sel == BEQ_EVT_DATA) ? data_event : alloc_event;

    beq_counter #(.W(CW)) u_cnt (
        .clk(clk),
        .reset(reset),
        .enable(cnt_enable),
        .edge_mode(edge_mode), // see R3
        .clear(cnt_clear),
        .event_in(sel_event), // see R16
        .count(count)
    );

    // assertions
    property p_new_and;
        @(posedge clk) disable iff (reset)
        (new_model && req.valid && !rw_match) |=> !alloc_event;
    endproperty
    a_new_and: assert property (p_new_and) else $error("alloc event without rw match"); // see R4

    property p_old_src;
        @(posedge clk) disable iff (reset)
        (!src_match) |=> !alloc_event;
    endproperty
    a_old_src: assert property (p_old_src) else $error("alloc event without source match"); // see R5

    property p_prefetch;
        @(posedge clk) disable iff (reset)
        (req.valid && req.prefetch && !evt_mask[QM_PREFETCH]) |=> !alloc_event;
    endproperty
    a_prefetch: assert property (p_prefetch) else $error("prefetch counted"); // see R2

    property p_other;
        @(posedge clk) disable iff (reset)
        (req.valid && !req.own && !evt_mask[QM_OTHER]) |=> !alloc_event;
    endproperty
    a_other: assert property (p_other) else $error("other agent counted"); // see R1

    property p_drive_full;
        @(posedge clk) disable iff (reset)
        (data.start && data.drive && data.full_line) ##1 (!(data.start && data.drive)) [*4]
            |-> drive_active && $past(drive_active, 3) ##1 !drive_active;
    endproperty
    a_drive_full: assert property (p_drive_full) else $error("full drive length wrong"); // see R11

    property p_read_part;
        @(posedge clk) disable iff (reset)
        (data.start && data.read && !data.full_line) ##1 !data.start [*2] |-> $past(read_active, 1) ##1 !read_active;
    endproperty
    a_read_part: assert property (p_read_part) else $error("partial read length wrong"); // see R12

    property p_data_sel;
        @(posedge clk) disable iff (reset)
        (evt_mask[DA_DRV] && drive_active) |=> data_event;
    endproperty
    a_data_sel: assert property (p_data_sel) else $error("drive activity missed"); // see R10

    property p_count_level;
        @(posedge clk) disable iff (reset)
        (cnt_enable && !cnt_clear && !edge_mode && sel_event) |=> count == $past(count) + CW'(1);
    endproperty
    a_count_level: assert property (p_count_level) else $error("level count missed"); // see R16

    property p_count_edge;
        @(posedge clk) disable iff (reset)
        (edge_mode && !cnt_clear && sel_event && $past(sel_event)) |=> count == $past(count);
    endproperty
    a_count_edge: assert property (p_count_edge) else $error("edge mode double count"); // see R16

    // qualifier checks rebuilt from the mask fields
    property p_priv_blind;
        @(posedge clk) disable iff (reset)
        (req.valid && privilege_level && pf_ok && src_match && new_model && req_match && rw_match && mem_match)
            |=> alloc_event;
    endproperty
    a_priv_blind: assert property (p_priv_blind) else $error("privileged request dropped"); // see R7

    property p_old_rw;
        @(posedge clk) disable iff (reset)
        (!new_model && req.valid && pf_ok && src_match && (evt_mask[QM_ALL_READ] || evt_mask[QM_ALL_WRITE])
            && !req_match && !rw_match) |=> !alloc_event;
    endproperty
    a_old_rw: assert property (p_old_rw) else $error("memory type used with rw selector"); // see R6

    property p_req_default;
        @(posedge clk) disable iff (reset)
        (evt_mask[QM_REQ_LSB +: QM_REQ_W] == REQ_TYPE_DEFAULT) |-> req_match;
    endproperty
    a_req_default: assert property (p_req_default) else $error("default request type not matching"); // see R13

    property p_own;
        @(posedge clk) disable iff (reset)
        (req.valid && req.own && !evt_mask[QM_OWN]) |=> !alloc_event;
    endproperty
    a_own: assert property (p_own) else $error("own request counted"); // see R14

    property p_alloc_one;
        @(posedge clk) disable iff (reset)
        alloc_event |-> $past(req.valid);
    endproperty
    a_alloc_one: assert property (p_alloc_one) else $error("alloc event without allocation"); // see R8

    // condition lengths and selection
    property p_drive_part;
        @(posedge clk) disable iff (reset)
        (data.start && data.drive && !data.full_line) ##1 (!data.start) [*2] |-> $past(drive_active, 1) ##1 !drive_active;
    endproperty
    a_drive_part: assert property (p_drive_part) else $error("partial drive length wrong"); // see R11

    property p_read_full;
        @(posedge clk) disable iff (reset)
        (data.start && data.read && data.full_line) ##1 (!(data.start && data.read)) [*4]
            |-> read_active && $past(read_active, 3) ##1 !read_active;
    endproperty
    a_read_full: assert property (p_read_full) else $error("full read length wrong"); // see R12

    property p_data_own;
        @(posedge clk) disable iff (reset)
        (evt_mask[DA_OWN] && read_active) |=> data_event;
    endproperty
    a_data_own: assert property (p_data_own) else $error("own read activity missed"); // see R9

    property p_clear;
        @(posedge clk) disable iff (reset)
        cnt_clear |=> count == CW'(0);
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero count"); // see R16
endmodule : beq_top
`default_nettype wire

// *** testbench/beq_bus_agent.sv ***
// other bus agents: allocation requests and data phases
`timescale 1ns/1ps
`default_nettype none
module beq_bus_agent
    import beq_pkg::*;
(
    input wire logic clk,       // processor clock
    output beq_req_t req,       // request into the queue
    output beq_data_t data      // data phase on the bus
);
    beq_req_t idle_r;
    beq_data_t idle_d;
    initial begin
        req = '0;
        data = '0;
    end
    // hold a request n clocks, then leave inverted leftovers with valid low
    task automatic send_req(input beq_req_t r, input int n);
        idle_r = ~r;
        idle_r.valid = 1'b0;
        @(posedge clk);
        req <= r;
        repeat (n) @(posedge clk);
        req <= idle_r;
    endtask : send_req
    // one start pulse, qualifiers scrambled afterwards
    task automatic send_phase(input logic drv, input logic rd, input logic full);
        idle_d = ~beq_data_t'{1'b1, drv, rd, full};
        @(posedge clk);
        data <= '{1'b1, drv, rd, full};
        @(posedge clk);
        data <= idle_d;
    endtask : send_phase
endmodule : beq_bus_agent
`default_nettype wire

// *** testbench/beq_top_tb.sv ***
// self-checking bench for the bus event qualifier
`timescale 1ns/1ps
`default_nettype none
module beq_top_tb;
    import beq_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic new_model = 1'b0;
    logic cnt_enable = 1'b0;
    logic edge_mode = 1'b0;
    logic cnt_clear = 1'b0;
    logic privilege_level = 1'b0;
    logic [MASK_W-1:0] evt_mask = '0;
    beq_evt_t evt_sel = BEQ_EVT_ALLOC;
    beq_req_t req;
    beq_data_t data;
    logic alloc_event, data_event, drive_active, read_active;
    logic [CNT_W-1:0] count;
    int error_cnt = 0;
    int cmp_count = 0;
    beq_req_t ra, rb, rp, rw;
    always #20 clk = ~clk;
    beq_bus_agent agent (.clk(clk), .req(req), .data(data));
    beq_top dut (.clk(clk), .reset(reset), .evt_mask(evt_mask), .evt_sel(evt_sel), .new_model(new_model),
        .cnt_enable(cnt_enable), .edge_mode(edge_mode), .cnt_clear(cnt_clear), .req(req),
        .privilege_level(privilege_level), .data(data), .alloc_event(alloc_event), .data_event(data_event),
        .drive_active(drive_active), .read_active(read_active), .count(count));
    task automatic check(input string nm, input logic [CNT_W-1:0] exp, input logic [CNT_W-1:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : check
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    function automatic beq_req_t mk_req(logic [4:0] rt, logic rd, logic wr, logic own, logic pf);
        return '{1'b1, rt, rd, wr, 5'h1F, own, pf, 1'b1};
    endfunction : mk_req
    function automatic logic [15:0] mk_mask(logic [4:0] rt, logic rd, logic wr, logic [4:0] mem, logic own,
        logic oth, logic pf);
        return {pf, oth, own, 1'b0, mem, wr, rd, rt};
    endfunction : mk_mask
    // one request under a given mask and model, event looked at one clock later
    task automatic alloc(input logic nm, input logic [15:0] m, input logic exp, input beq_req_t r);
        @(posedge clk);
        new_model <= nm;
        evt_mask <= m;
        agent.send_req(r, 1);
        #1 check("alloc_event", {39'h0, exp}, {39'h0, alloc_event});
        @(posedge clk);
    endtask : alloc
    // one data phase: length of the condition and the counted total
    task automatic phase(input logic [15:0] m, input logic edg, input logic drv, input logic rd,
        input logic full, input int exp_cnt, input int exp_len, input int exp_evt);
        int len;
        int evt;
        len = 0;
        evt = 0;
        @(posedge clk);
        evt_sel <= BEQ_EVT_DATA;
        evt_mask <= m;
        edge_mode <= edg;
        cnt_clear <= 1'b1;
        @(posedge clk);
        cnt_clear <= 1'b0;
        agent.send_phase(drv, rd, full);
        repeat (8) begin
            #1 if ((drv ? drive_active : read_active) === 1'b1) len++;
            if (data_event === 1'b1) evt++;
            @(posedge clk);
        end
        #1 check("active_len", CNT_W'(exp_len), CNT_W'(len));
        check("event_len", CNT_W'(exp_evt), CNT_W'(evt));
        check("data_count", CNT_W'(exp_cnt), count);
    endtask : phase
    // bounded run time
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        ra = mk_req(5'h05, 1'b1, 1'b0, 1'b0, 1'b0);
        rb = mk_req(5'h05, 1'b1, 1'b0, 1'b1, 1'b0);
        rp = mk_req(5'h05, 1'b1, 1'b0, 1'b0, 1'b1);
        rw = mk_req(5'h05, 1'b0, 1'b1, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        cnt_enable <= 1'b1;
        edge_mode <= 1'b0;
        @(posedge clk);
        #1 check("reset_count", '0, count);
        alloc(1'b1, mk_mask(5'h01, 1'b1, 1'b0, 5'h1F, 1'b0, 1'b1, 1'b0), 1'b1, ra);
        alloc(1'b1, mk_mask(5'h01, 1'b1, 1'b0, 5'h1F, 1'b0, 1'b1, 1'b0), 1'b0, rb);
        alloc(1'b1, mk_mask(5'h01, 1'b1, 1'b0, 5'h1F, 1'b1, 1'b0, 1'b0), 1'b1, rb);
        alloc(1'b1, mk_mask(5'h01, 1'b1, 1'b0, 5'h00, 1'b0, 1'b1, 1'b0), 1'b0, ra);
        alloc(1'b1, mk_mask(5'h03, 1'b1, 1'b0, 5'h1F, 1'b0, 1'b1, 1'b0), 1'b0, ra);
        alloc(1'b1, mk_mask(5'h01, 1'b1, 1'b0, 5'h1F, 1'b0, 1'b1, 1'b0), 1'b0, rp);
        alloc(1'b1, mk_mask(5'h01, 1'b1, 1'b0, 5'h1F, 1'b0, 1'b1, 1'b1), 1'b1, rp);
        alloc(1'b0, mk_mask(5'h03, 1'b0, 1'b0, 5'h1F, 1'b0, 1'b1, 1'b0), 1'b1, ra);
        alloc(1'b0, mk_mask(5'h03, 1'b0, 1'b0, 5'h00, 1'b0, 1'b1, 1'b0), 1'b0, ra);
        alloc(1'b0, mk_mask(5'h01, 1'b1, 1'b0, 5'h1F, 1'b0, 1'b1, 1'b0), 1'b0, rb);
        alloc(1'b0, mk_mask(5'h03, 1'b1, 1'b0, 5'h1F, 1'b0, 1'b1, 1'b0), 1'b0, rw);
        privilege_level <= 1'b1;
        alloc(1'b1, mk_mask(5'h01, 1'b1, 1'b0, 5'h1F, 1'b0, 1'b1, 1'b0), 1'b1, ra);
        // back-to-back line allocations then one chunk, level counting
        cnt_clear <= 1'b1;
        @(posedge clk);
        cnt_clear <= 1'b0;
        agent.send_req(ra, 2);
        rw = ra;
        rw.full_line = 1'b0;
        agent.send_req(rw, 1);
        repeat (3) @(posedge clk);
        #1 check("alloc_count", 40'h00_0000_0003, count);
        phase(16'h0001, 1'b0, 1'b1, 1'b0, 1'b1, 4, 4, 4);
        phase(16'h0001, 1'b0, 1'b1, 1'b0, 1'b0, 2, 2, 2);
        phase(16'h0002, 1'b0, 1'b0, 1'b1, 1'b1, 4, 4, 4);
        phase(16'h0002, 1'b1, 1'b0, 1'b1, 1'b0, 1, 2, 2);
        phase(16'h0002, 1'b0, 1'b1, 1'b0, 1'b1, 0, 4, 0);
        // counter disabled: event still seen, nothing counted
        cnt_enable <= 1'b0;
        phase(16'h0001, 1'b0, 1'b1, 1'b0, 1'b1, 0, 4, 4);
        wrap_up();
    end
endmodule : beq_top_tb
`default_nettype wire
